// *** shared/gpio_port_regs.vh ***
// register offsets, field positions, reset values and pin masks of the port block
// assumes byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define NPORT 11
`define NPIN 88
`define NGROUP 22

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define PULLUP_A_OFS 12'h360
`define PULLUP_B_OFS 12'h364
`define PULLUP_C_OFS 12'h368
`define READBACK_OFS 12'h36c
`define PROTECT_OFS 12'h370
`define PMODE_OFS 12'h374
`define DIR_BASE_OFS 12'h380
`define DATA_BASE_OFS 12'h3d0
`define PORT8_DATA_OFS 12'h3f0

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define LATCH_RB_BIT 0
`define DIR9_WE_BIT 2
`define SOFT_RESET_BIT 7
`define PORT4_LOW_PU_BIT 1
`define MODE_SINGLE 2'h0
`define MODE_EXPAND 2'h1
`define MODE_MICRO 2'h3
`define PULLUP_B_RST_LOW 8'h00
`define PULLUP_B_RST_HIGH 8'h02
`define NMI_PIN 69
`define OD_PIN_A 56
`define OD_PIN_B 57
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// pin masks
// ----------------------------------------------------------------
// pins serving the external bus: ports 0 to 5
`define BUS_PIN_MASK_DEF 88'h0000_0000_ffff_ffff_ffff
// pins whose pull-ups are off in expansion modes: ports 0-3, port4 low, port5
`define PU_OFF_MASK_DEF 88'h0000_0000_ff0f_ffff_ffff
`endif

// *** design/gpio_pullup_port_control.v ***
// port pin control: direction, data latches, grouped pull-ups, readback and mode
// assumes an AXI4-Lite master on aclk and pad cells that take out, oe and pullup
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "gpio_port_regs.vh"

module gpio_pullup_port_control #(
  parameter [`NPIN-1:0] BUS_PIN_MASK = `BUS_PIN_MASK_DEF,
  parameter [`NPIN-1:0] PU_OFF_MASK = `PU_OFF_MASK_DEF
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address and data
  input wire [11:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // axi4-lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read
  input wire [11:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // pins
  input wire mode_select_pin,
  input wire [`NPIN-1:0] pin_in,
  output reg [`NPIN-1:0] pin_out,
  output reg [`NPIN-1:0] pin_oe,
  output reg [`NPIN-1:0] pin_pullup
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [`NPIN-1:0] dir_q;
  reg [`NPIN-1:0] latch_q;
  reg [7:0] pullup_a_q;
  reg [7:0] pullup_b_q;
  reg [5:0] pullup_c_q;
  reg latch_readback_sel_q;
  reg dir9_write_enable_q;
  reg [1:0] processor_mode_field_q;
  reg soft_reset_q;
  reg [11:0] waddr_q;
  reg [7:0] wdata_q;
  reg wstrb_q;
  reg [`NPIN-1:0] sync1_q;
  reg [`NPIN-1:0] sync2_q;
  reg [`NPIN-1:0] sync3_q;
  reg [`NPIN-1:0] pin_lvl_q;
  reg msel1_q;
  reg msel2_q;
  reg msel3_q;
  reg msel_lvl_q;

  wire expand_mode = processor_mode_field_q[0];
  wire wr_fire = ~awready & ~wready & ~bvalid;
  wire [`NPIN-1:0] od_mask = ({{(`NPIN-1){1'b0}}, 1'b1} << `OD_PIN_A) |
                             ({{(`NPIN-1){1'b0}}, 1'b1} << `OD_PIN_B);
  wire [`NPIN-1:0] nmi_mask = {{(`NPIN-1){1'b0}}, 1'b1} << `NMI_PIN;
  // port4 low nibble is bit 1 of register b, high nibble bit 0
  wire [`NGROUP-1:0] pu_group = {pullup_c_q, pullup_b_q[7:2], pullup_b_q[0],
                                 pullup_b_q[1], pullup_a_q};

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  // three stages; a level is taken once stages two and three agree
  always @(posedge aclk)
  begin
    sync1_q <= pin_in;
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
    msel1_q <= mode_select_pin;
    msel2_q <= msel1_q;
    msel3_q <= msel2_q;
    if (!aresetn)
    begin
      pin_lvl_q <= {`NPIN{1'b0}};
    end
    else
    begin
      pin_lvl_q <= (pin_lvl_q & ~(sync2_q ^ sync3_q)) | (sync3_q & ~(sync2_q ^ sync3_q));
    end
    if (msel2_q == msel3_q)
    begin
      msel_lvl_q <= msel3_q;
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  reg [`NPIN-1:0] dir_wmask;
  reg [`NPIN-1:0] data_wmask;
  reg [`NPIN-1:0] wide_wdata;
  reg wr_hit;
  integer i;

  // which pin bits the pending write may change
  always @*
  begin
    dir_wmask = {`NPIN{1'b0}};
    data_wmask = {`NPIN{1'b0}};
    wide_wdata = {`NPORT{wdata_q}};
    wr_hit = 1'b0;
    for (i = 0; i < `NPORT; i = i + 1)
    begin
      if (waddr_q == `DIR_BASE_OFS + 4 * i)
      begin
        wr_hit = 1'b1;
        if (i != 9 || dir9_write_enable_q)
        begin
          dir_wmask[8*i +: 8] = 8'hff;
        end
      end
      if (waddr_q == `DATA_BASE_OFS + 4 * i)
      begin
        wr_hit = 1'b1;
        data_wmask[8*i +: 8] = 8'hff;
      end
    end
    case (waddr_q)
      `PULLUP_A_OFS, `PULLUP_B_OFS, `PULLUP_C_OFS, `READBACK_OFS, `PROTECT_OFS, `PMODE_OFS:
        wr_hit = 1'b1;
      default:
        wr_hit = wr_hit;
    endcase
    if (expand_mode)
    begin
      dir_wmask = dir_wmask & ~BUS_PIN_MASK;
    end
    if (expand_mode)
    begin
      data_wmask = data_wmask & ~BUS_PIN_MASK;
    end
    dir_wmask = dir_wmask & ~nmi_mask;
    data_wmask = data_wmask & ~nmi_mask;
    if (!wstrb_q)
    begin
      dir_wmask = {`NPIN{1'b0}};
      data_wmask = {`NPIN{1'b0}};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  wire do_wr = wr_fire & wstrb_q;

  // hardware reset, software reset and register writes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dir_q <= {`NPIN{1'b0}};
      latch_q <= {`NPIN{1'b0}};
      pullup_a_q <= 8'h00;
      pullup_c_q <= 6'h00;
      latch_readback_sel_q <= 1'b0;
      dir9_write_enable_q <= 1'b0;
      soft_reset_q <= 1'b0;
      pullup_b_q <= msel_lvl_q ? `PULLUP_B_RST_HIGH : `PULLUP_B_RST_LOW;
      processor_mode_field_q <= msel_lvl_q ? `MODE_MICRO : `MODE_SINGLE;
    end
    else if (soft_reset_q)
    begin
      dir_q <= {`NPIN{1'b0}};
      pullup_a_q <= 8'h00;
      pullup_c_q <= 6'h00;
      latch_readback_sel_q <= 1'b0;
      dir9_write_enable_q <= 1'b0;
      soft_reset_q <= 1'b0;
      pullup_b_q <= expand_mode ? `PULLUP_B_RST_HIGH : `PULLUP_B_RST_LOW;
    end
    else
    begin
      soft_reset_q <= 1'b0;
      // only the completing write may touch direction and latch bits
      if (wr_fire)
      begin
        dir_q <= (dir_q & ~dir_wmask) | (wide_wdata & dir_wmask);
        latch_q <= (latch_q & ~data_wmask) | (wide_wdata & data_wmask);
      end
      // enable lasts for the next write only
      if (wr_fire && waddr_q != `PROTECT_OFS)
      begin
        dir9_write_enable_q <= 1'b0;
      end
      if (do_wr && waddr_q == `PULLUP_A_OFS)
      begin
        pullup_a_q <= wdata_q;
      end
      if (do_wr && waddr_q == `PULLUP_B_OFS)
      begin
        pullup_b_q <= wdata_q;
      end
      if (do_wr && waddr_q == `PULLUP_C_OFS)
      begin
        pullup_c_q <= wdata_q[5:0];
      end
      if (do_wr && waddr_q == `READBACK_OFS)
      begin
        latch_readback_sel_q <= wdata_q[`LATCH_RB_BIT];
      end
      if (do_wr && waddr_q == `PROTECT_OFS)
      begin
        dir9_write_enable_q <= wdata_q[`DIR9_WE_BIT];
      end
      if (do_wr && waddr_q == `PMODE_OFS)
      begin
        processor_mode_field_q <= wdata_q[1:0];
        soft_reset_q <= wdata_q[`SOFT_RESET_BIT];
        if (processor_mode_field_q == `MODE_SINGLE &&
            (wdata_q[1:0] == `MODE_EXPAND || wdata_q[1:0] == `MODE_MICRO))
        begin
          pullup_b_q[`PORT4_LOW_PU_BIT] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive and pull-ups
  // ----------------------------------------------------------------
  reg [`NPIN-1:0] pu_pin;
  integer p;

  always @*
  begin
    pu_pin = {`NPIN{1'b0}};
    for (p = 0; p < `NPIN; p = p + 1)
    begin
      pu_pin[p] = pu_group[p / 4];
    end
  end

  // registered pad controls
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out <= {`NPIN{1'b0}};
      pin_oe <= {`NPIN{1'b0}};
      pin_pullup <= {`NPIN{1'b0}};
    end
    else
    begin
      pin_out <= latch_q & ~od_mask & ~nmi_mask;
      pin_oe <= ((dir_q & ~od_mask) | (dir_q & od_mask & ~latch_q)) & ~nmi_mask;
      pin_pullup <= pu_pin & ~dir_q & ~od_mask & ~nmi_mask &
                    ~(expand_mode ? PU_OFF_MASK : {`NPIN{1'b0}});
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  reg [7:0] rd_byte;
  reg rd_hit;
  reg [`NPIN-1:0] port_view;
  integer k;

  always @*
  begin
    port_view = (dir_q & latch_q) | (~dir_q & pin_lvl_q);
    if (latch_readback_sel_q)
    begin
      port_view[15:8] = latch_q[15:8];
    end
    port_view[`NMI_PIN] = pin_lvl_q[`NMI_PIN];
    rd_byte = 8'h00;
    rd_hit = 1'b0;
    for (k = 0; k < `NPORT; k = k + 1)
    begin
      if (araddr == `DIR_BASE_OFS + 4 * k)
      begin
        rd_hit = 1'b1;
        rd_byte = dir_q[8*k +: 8];
      end
      if (araddr == `DATA_BASE_OFS + 4 * k)
      begin
        rd_hit = 1'b1;
        rd_byte = port_view[8*k +: 8];
      end
    end
    case (araddr)
      `PULLUP_A_OFS:
      begin
        rd_hit = 1'b1;
        rd_byte = pullup_a_q;
      end
      `PULLUP_B_OFS:
      begin
        rd_hit = 1'b1;
        rd_byte = pullup_b_q;
      end
      `PULLUP_C_OFS:
      begin
        rd_hit = 1'b1;
        rd_byte = {2'h0, pullup_c_q};
      end
      `READBACK_OFS:
      begin
        rd_hit = 1'b1;
        rd_byte = {7'h00, latch_readback_sel_q};
      end
      `PROTECT_OFS:
      begin
        rd_hit = 1'b1;
        rd_byte = {5'h00, dir9_write_enable_q, 2'h0};
      end
      `PMODE_OFS:
      begin
        rd_hit = 1'b1;
        rd_byte = {6'h00, processor_mode_field_q};
      end
      default:
        rd_hit = rd_hit;
    endcase
  end

  // ----------------------------------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------------------------------
  // address and data taken in either order; response after both
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h0000_0000;
      waddr_q <= 12'h000;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        waddr_q <= {awaddr[11:2], 2'b00};
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        wdata_q <= wdata[7:0];
        wstrb_q <= wstrb[0];
      end
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h000000, rd_byte};
        rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // gpio_pullup_port_control

// *** test/port_ctl_sva.sv ***
// checker of the port block: bus handshakes and pad relations
// assumes it is bound to the port block and sees only its ports
`timescale 1ns/1ps
`include "gpio_port_regs.vh"
module port_ctl_sva (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire rvalid,
  input wire rready,
  // pads
  input wire [`NPIN-1:0] pin_out,
  input wire [`NPIN-1:0] pin_oe,
  input wire [`NPIN-1:0] pin_pullup
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  // read address taken
  sequence rd_take;
    arvalid && arready;
  endsequence
  a_wr_answer: assert property (wr_take |-> ##2 bvalid) else $error("late write response");
  a_rd_answer: assert property (rd_take |=> rvalid) else $error("late read response");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_wr_refuse: assert property (bvalid |-> !awready && !wready) else $error("write not refused");
  a_rd_refuse: assert property (rvalid |-> !arready) else $error("read not refused");
  a_od_float: assert property (pin_out[`OD_PIN_B:`OD_PIN_A] == 2'h0)
    else $error("open drain driven high");
  a_od_nopull: assert property (pin_pullup[`OD_PIN_B:`OD_PIN_A] == 2'h0)
    else $error("open drain pulled up");
  a_pull_input: assert property ((pin_pullup & pin_oe) == {`NPIN{1'b0}})
    else $error("pull-up on output pin");
  a_nmi_input: assert property (!pin_oe[`NMI_PIN] && !pin_pullup[`NMI_PIN])
    else $error("nmi pin not input");
endmodule // port_ctl_sva

bind gpio_pullup_port_control port_ctl_sva u_sva (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid,
  .rready, .pin_out, .pin_oe, .pin_pullup);

// *** test/pin_world.sv ***
// far-side pin model: outside drivers and pull-up resistors
// assumes pad outputs of the port block and levels from the bench
`timescale 1ns/1ps
`include "gpio_port_regs.vh"
module pin_world (
  // pad side
  input wire [`NPIN-1:0] pin_out,
  input wire [`NPIN-1:0] pin_oe,
  input wire [`NPIN-1:0] pin_pullup,
  // bench side
  input wire [`NPIN-1:0] ext_level,
  output wire [`NPIN-1:0] pin_in
);
  // pad driver first, then pull-up, then outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pullup | ext_level));
endmodule // pin_world

// *** test/tb_gpio_pullup_port_control.sv ***
// self-checking bench for the port block over its register bus
// assumes the pin model and checker are compiled alongside
`timescale 1ns/1ps
`include "gpio_port_regs.vh"
module tb_gpio_pullup_port_control;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [11:0] awaddr = 12'h000;
  reg awvalid = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'hf;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg [11:0] araddr = 12'h000;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  reg mode_select_pin = 1'b0;
  reg [87:0] ext_level = 88'h0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [87:0] pin_in, pin_out, pin_oe, pin_pullup;
  integer fail_count = 0;
  integer num_checks = 0;
  integer cyc = 0;
  localparam [1:0] OK = `RESP_OKAY;
  localparam [11:0] DIR = `DIR_BASE_OFS;
  localparam [11:0] DAT = `DATA_BASE_OFS;

  gpio_pullup_port_control dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .mode_select_pin, .pin_in, .pin_out, .pin_oe,
    .pin_pullup);
  pin_world far (.pin_out, .pin_oe, .pin_pullup, .ext_level, .pin_in);

  // clock and hang guard
  always #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      fail_count = fail_count + 1;
      print_verdict;
    end
  end

  // compare one value
  task chk(input [87:0] g, input [87:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
        fail_count = fail_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  // bus write with expected response
  task wr(input [11:0] a, input [7:0] d, input [1:0] er);
    reg ad, wd;
    begin
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && wd))
      begin
        @(posedge aclk);
        ad = ad | awready;
        wd = wd | wready;
        awvalid <= !ad;
        wvalid <= !wd;
      end
      while (!bvalid) @(posedge aclk);
      bready <= 1'b1;
      @(posedge aclk);
      bready <= 1'b0;
      chk(bresp, er);
    end
  endtask

  // bus read with expected data and response
  task rd(input [11:0] a, input [7:0] e, input [1:0] er);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      @(posedge aclk);
      while (!arready) @(posedge aclk);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge aclk);
      rready <= 1'b1;
      @(posedge aclk);
      rready <= 1'b0;
      chk(rdata, {24'h0, e});
      chk(rresp, er);
    end
  endtask

  // counts and verdict
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // main sequence
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`PULLUP_B_OFS, 8'h00, OK);
    wr(`PULLUP_A_OFS, 8'h03, OK);
    wr(DIR, 8'h0f, OK);
    wr(DAT, 8'h03, OK);
    repeat (6) @(posedge aclk);
    chk(pin_oe[7:0], 8'h0f);
    chk(pin_pullup[7:0], 8'hf0);
    ext_level[71:64] <= 8'h20;
    wr(DIR + 12'h020, 8'hff, OK);
    rd(DIR + 12'h020, 8'hdf, OK);
    wr(DIR + 12'h020, 8'h0f, OK);
    wr(`PORT8_DATA_OFS, 8'hff, OK);
    repeat (6) @(posedge aclk);
    rd(`PORT8_DATA_OFS, 8'h2f, OK);
    chk(pin_out[71:64], 8'hdf);
    wr(DIR + 12'h004, 8'h00, OK);
    wr(DAT + 12'h004, 8'h5a, OK);
    repeat (6) @(posedge aclk);
    rd(DAT + 12'h004, 8'h00, OK);
    wr(`READBACK_OFS, 8'h01, OK);
    rd(DAT + 12'h004, 8'h5a, OK);
    wr(`PULLUP_B_OFS, 8'h40, OK);
    wr(DIR + 12'h01c, 8'h03, OK);
    wr(DAT + 12'h01c, 8'h01, OK);
    repeat (4) @(posedge aclk);
    chk(pin_oe[59:56], 4'h2);
    chk(pin_pullup[59:56], 4'hc);
    wr(DIR + 12'h01c, 8'h00, OK);
    repeat (4) @(posedge aclk);
    chk(pin_pullup[59:56], 4'hc);
    wr(DIR + 12'h024, 8'hff, OK);
    rd(DIR + 12'h024, 8'h00, OK);
    wr(`PROTECT_OFS, 8'h04, OK);
    wr(DIR + 12'h024, 8'hff, OK);
    rd(DIR + 12'h024, 8'hff, OK);
    wr(`PMODE_OFS, 8'h01, OK);
    rd(`PULLUP_B_OFS, 8'h42, OK);
    wr(`PULLUP_A_OFS, 8'h07, OK);
    rd(`PULLUP_A_OFS, 8'h07, OK);
    wstrb <= 4'h0;
    wr(`PULLUP_A_OFS, 8'hff, OK);
    wstrb <= 4'hf;
    rd(`PULLUP_A_OFS, 8'h07, OK);
    chk(pin_pullup[7:0], 8'h00);
    wr(DIR, 8'h00, OK);
    rd(DIR, 8'h0f, OK);
    wr(DAT, 8'hff, OK);
    repeat (4) @(posedge aclk);
    chk(pin_out[7:0], 8'h03);
    wr(`PMODE_OFS, 8'h81, OK);
    rd(`PULLUP_B_OFS, 8'h02, OK);
    wr(`PMODE_OFS, 8'h00, OK);
    wr(`PMODE_OFS, 8'h80, OK);
    rd(`PULLUP_B_OFS, 8'h00, OK);
    wr(`PMODE_OFS, 8'h03, OK);
    rd(`PULLUP_B_OFS, 8'h02, OK);
    wr(`PULLUP_B_OFS, 8'h00, OK);
    wr(`PMODE_OFS, 8'h83, OK);
    rd(`PULLUP_B_OFS, 8'h02, OK);
    wr(12'hffc, 8'h55, `RESP_SLVERR);
    rd(12'hffc, 8'h00, `RESP_SLVERR);
    mode_select_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`PULLUP_B_OFS, 8'h02, OK);
    print_verdict;
  end
endmodule // tb_gpio_pullup_port_control
